/* verilog/pp_port.sv */
// Summary of operation
// R1: Identification bytes readable even when locked
// R2: Identification bytes at own addresses zero-two
// R3: Calibration bytes at addresses zero-three, high
// R4: Reset loads 1 MHz calibration into trim
// R5: Crystal rise acts per action select
// R6: Code 00 latches address byte
// R7: Code 01 latches data byte
// R8: Write strobe executes latched command
// R9: Decode erase, fuse, lock, flash, EEPROM writes
// R10: Decode signature, fuse, flash, EEPROM reads
// R11: Ready/busy low while programming
// R12: Data bus driven only while enable low
// R13: First byte select picks low/high
// R14: Second byte select picks second high
// R15: Page load fills the page buffer
// R16: Programmer enters mode with selects low; no entry check, the port is active from reset
// R17: Flash 128 pages of 32 words
// R18: EEPROM 128 pages of 4 bytes
// R19: Command and address kept across operations
// R20: Latching ignored while busy
`timescale 1ns/100ps
module pp_port #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identification value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary identification value
  parameter logic [7:0] SIG_BYTE2 = 8'h01 // Arbitrary identification value
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Programmer control pins
  input wire logic crystal_strobe_pin_in,
  input wire logic action_select_0_in,
  input wire logic action_select_1_in,
  input wire logic byte_select_lo_hi_in,
  input wire logic byte_select_second_in,
  input wire logic page_load_in,
  input wire logic write_n_in,
  input wire logic output_enable_n_in,
  // Bidirectional data bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  // Status pin
  output logic ready_busy_out,
  // Oscillator trim
  input wire logic osc_trim_load_in,
  input wire logic [7:0] osc_trim_data_in,
  output logic [7:0] osc_trim_reg_out
);
  typedef struct packed {
    pp_pkg::pp_state_t state;
    logic xtal;
    logic wr_n;
    logic pl;
    logic start;
    logic [7:0] cmd;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] dat_hi;
    logic [7:0] dat_lo;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] lock;
    logic [7:0] dout;
    logic doe_n;
    logic rdy;
    logic [7:0] trim;
    logic [1:0] warm;
  } pp_port_state_t;

  localparam int SYNC_W = 16;

  pp_port_state_t q, d;
  pp_mem_if mbus ();
  logic [SYNC_W-1:0] s;
  logic s_xtal, s_bs1, s_bs2, s_pl, s_wr_n, s_oe_n;
  logic [1:0] s_act;
  logic [7:0] s_data;
  logic xtal_rise, wr_fall, pl_rise, idle, locked;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and storage

  pp_sync #(.W(SYNC_W)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pins_in({crystal_strobe_pin_in, action_select_1_in, action_select_0_in, byte_select_lo_hi_in,
      byte_select_second_in, page_load_in, write_n_in, output_enable_n_in, data_in}),
    .pins_out(s)
  );

  pp_nvm u_nvm (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .bus(mbus.mem)
  );

  // Unpack synchronised pins
  assign {s_xtal, s_act, s_bs1, s_bs2, s_pl, s_wr_n, s_oe_n, s_data} = s;

  // Edge detectors on synchronised pins
  assign xtal_rise = s_xtal && !q.xtal;
  assign wr_fall = !s_wr_n && q.wr_n;
  assign pl_rise = s_pl && !q.pl;
  assign idle = (q.state == pp_pkg::ST_IDLE);
  assign locked = (q.lock[1:0] != 2'h3);

  ////////////////////////////////////////////////////////////////////////
  // Storage requests

  // Flash address spans bits 11..0, EEPROM bits 8..0
  // R17: flash page addressing
  // R18: EEPROM page addressing
  assign mbus.addr = {q.addr_hi[3:0], q.addr_lo};
  assign mbus.wdata = {q.dat_hi, q.dat_lo};
  assign mbus.start = q.start;
  assign mbus.ee_keep = !q.fuse_hi[pp_pkg::EESAVE_BIT];
  // R15: page buffer load
  assign mbus.page_load = pl_rise && idle;

  // Storage operation from the latched command
  // R9: write command decode
  always_comb begin
    case (q.cmd)
      pp_pkg::CMD_ERASE: mbus.op = pp_pkg::MOP_ERASE;
      pp_pkg::CMD_WR_FLASH: mbus.op = pp_pkg::MOP_WR_FLASH;
      pp_pkg::CMD_WR_EE: mbus.op = pp_pkg::MOP_WR_EE;
      default: mbus.op = pp_pkg::MOP_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data selection

  // R10: read command decode
  always_comb begin
    rd_byte = pp_pkg::ERASED_BYTE;
    case (q.cmd)
      pp_pkg::CMD_RD_SIG: begin
        // R1: identification ignores locks
        // R2: identification addresses
        // R3: calibration on high byte
        if (q.addr_lo == 8'h00) begin
          rd_byte = s_bs1 ? pp_pkg::CAL_1MHZ : SIG_BYTE0;
        end else if (q.addr_lo == 8'h01) begin
          rd_byte = s_bs1 ? pp_pkg::CAL_2MHZ : SIG_BYTE1;
        end else if (q.addr_lo == 8'h02) begin
          rd_byte = s_bs1 ? pp_pkg::CAL_4MHZ : SIG_BYTE2;
        end else if (q.addr_lo == 8'h03 && s_bs1) begin
          rd_byte = pp_pkg::CAL_8MHZ;
        end
      end
      pp_pkg::CMD_RD_FUSE: begin
        // R14: second select picks upper fuse
        if (!s_bs2 && !s_bs1) begin
          rd_byte = q.fuse_lo;
        end else if (s_bs2 && s_bs1) begin
          rd_byte = q.fuse_hi;
        end else if (!s_bs2 && s_bs1) begin
          rd_byte = q.lock;
        end
      end
      pp_pkg::CMD_RD_FLASH: begin
        // R13: low or high word byte
        if (!locked) begin
          rd_byte = s_bs1 ? mbus.rdata[15:8] : mbus.rdata[7:0];
        end
      end
      pp_pkg::CMD_RD_EE: begin
        if (!locked) begin
          rd_byte = mbus.ee_rdata;
        end
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next-state logic for latches, strobes and status
  always_comb begin
    d = q;
    d.xtal = s_xtal;
    d.wr_n = s_wr_n;
    d.pl = s_pl;
    d.start = 1'b0;
    // R12: drive only while enable low
    // Synchroniser flops clear to zero, which reads as enable low until flushed
    d.warm = {q.warm[0], 1'b1};
    d.doe_n = s_oe_n || !q.warm[1];
    d.dout = rd_byte;
    // R4: software trim reload
    if (osc_trim_load_in) begin
      d.trim = osc_trim_data_in;
    end
    // R5: crystal rise action
    // R20: no latching while busy
    // R19: latches hold until rewritten
    if (idle && xtal_rise) begin
      case (s_act)
        // R6: address byte latch
        pp_pkg::ACT_ADDR: begin
          if (s_bs1) begin
            d.addr_hi = s_data;
          end else begin
            d.addr_lo = s_data;
          end
        end
        // R7: data byte latch
        pp_pkg::ACT_DATA: begin
          if (s_bs1) begin
            d.dat_hi = s_data;
          end else begin
            d.dat_lo = s_data;
          end
        end
        pp_pkg::ACT_CMD: d.cmd = s_data;
        default: ;
      endcase
    end
    case (q.state)
      pp_pkg::ST_IDLE: begin
        // R8: write strobe executes command
        if (wr_fall) begin
          if (mbus.op != pp_pkg::MOP_NONE) begin
            d.state = pp_pkg::ST_START;
            d.start = 1'b1;
            d.rdy = 1'b0;
          end else if (q.cmd == pp_pkg::CMD_WR_FUSE && q.lock[0]) begin
            if (s_bs1) begin
              d.fuse_hi = q.dat_lo;
            end else begin
              d.fuse_lo = q.dat_lo;
            end
          end else if (q.cmd == pp_pkg::CMD_WR_LOCK) begin
            d.lock = q.lock & q.dat_lo;
          end
        end
      end
      pp_pkg::ST_START: d.state = pp_pkg::ST_BUSY;
      pp_pkg::ST_BUSY: begin
        // R11: ready again at completion
        if (mbus.done) begin
          d.state = pp_pkg::ST_IDLE;
          d.rdy = 1'b1;
          if (q.cmd == pp_pkg::CMD_ERASE) begin
            d.lock = pp_pkg::LOCK_RESET;
          end
        end
      end
      default: d.state = pp_pkg::ST_IDLE;
    endcase
  end

  // State register; trim starts from the 1 MHz value
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q.state <= pp_pkg::ST_IDLE;
      q.xtal <= 1'b0;
      q.wr_n <= 1'b0; // Same as the cleared synchroniser, so no false fall
      q.pl <= 1'b0;
      q.start <= 1'b0;
      q.cmd <= pp_pkg::CMD_RESET;
      q.addr_hi <= 8'h00;
      q.addr_lo <= 8'h00;
      q.dat_hi <= pp_pkg::ERASED_BYTE;
      q.dat_lo <= pp_pkg::ERASED_BYTE;
      q.fuse_lo <= pp_pkg::FUSE_LO_RESET;
      q.fuse_hi <= pp_pkg::FUSE_HI_RESET;
      q.lock <= pp_pkg::LOCK_RESET;
      q.dout <= 8'h00;
      q.doe_n <= 1'b1;
      q.rdy <= 1'b1;
      // R4: calibration copied during reset
      q.trim <= pp_pkg::CAL_1MHZ;
      q.warm <= 2'h0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign data_out = q.dout;
  assign data_oe_n_out = q.doe_n;
  assign ready_busy_out = q.rdy;
  assign osc_trim_reg_out = q.trim;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  busy_on_write_a: assert property (idle && wr_fall && mbus.op != pp_pkg::MOP_NONE |=> !ready_busy_out [*2]) // R11
    else $error("ready/busy not low after write strobe");
  cmd_latch_a: assert property (idle && xtal_rise && s_act == pp_pkg::ACT_CMD |=> q.cmd == $past(s_data)) // R5
    else $error("command byte not latched");
  idle_code_a: assert property (xtal_rise && s_act == pp_pkg::ACT_IDLE |=> // R5
    $stable({q.cmd, q.addr_hi, q.addr_lo, q.dat_hi, q.dat_lo}))
    else $error("idle action changed a latch");
  addr_low_a: assert property (idle && xtal_rise && s_act == pp_pkg::ACT_ADDR && !s_bs1 |=> // R6
    q.addr_lo == $past(s_data) && $stable(q.addr_hi))
    else $error("low address byte not latched");
  data_high_a: assert property (idle && xtal_rise && s_act == pp_pkg::ACT_DATA && s_bs1 |=> // R7
    q.dat_hi == $past(s_data) && $stable(q.dat_lo))
    else $error("high data byte not latched");
  bus_drive_a: assert property (s_oe_n |=> data_oe_n_out) // R12
    else $error("data bus driven with enable high");
  sig_read_a: assert property (!s_oe_n && q.cmd == pp_pkg::CMD_RD_SIG && !s_bs1 && q.addr_lo == 8'h02 |=> // R2
    data_out == SIG_BYTE2)
    else $error("wrong identification byte");
  cal_read_a: assert property (!s_oe_n && q.cmd == pp_pkg::CMD_RD_SIG && s_bs1 && q.addr_lo == 8'h03 |=> // R3
    data_out == pp_pkg::CAL_8MHZ)
    else $error("wrong calibration byte");
  busy_hold_a: assert property (!idle && xtal_rise |=> $stable(q.cmd) && $stable(q.addr_lo)) // R20
    else $error("latch changed while busy");
  erase_lock_a: assert property (q.state == pp_pkg::ST_BUSY && mbus.done && q.cmd == pp_pkg::CMD_ERASE |=> // R9
    q.lock == pp_pkg::LOCK_RESET && ready_busy_out)
    else $error("erase did not clear locks");
  trim_load_a: assert property (osc_trim_load_in |=> osc_trim_reg_out == $past(osc_trim_data_in)) // R4
    else $error("trim not loaded");
endmodule

/* verilog/pp_pkg.sv */
package pp_pkg;
  // Action select codes sampled on a crystal strobe rise
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // Command byte codes
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  // Memory geometry
  localparam int FLASH_WORDS = 4096;
  localparam int FLASH_PAGE_WORDS = 32;
  localparam int FLASH_ADDR_TOP_BIT = 11;
  localparam int EE_BYTES = 512;
  localparam int EE_PAGE_BYTES = 4;
  localparam int EEPROM_ADDR_TOP_BIT = 8;
  // Calibration bytes for 1, 2, 4 and 8 MHz
  localparam logic [7:0] CAL_1MHZ = 8'h80;
  localparam logic [7:0] CAL_2MHZ = 8'h81;
  localparam logic [7:0] CAL_4MHZ = 8'h82;
  localparam logic [7:0] CAL_8MHZ = 8'h83;
  // Values after reset
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] FUSE_LO_RESET = 8'he1;
  localparam logic [7:0] FUSE_HI_RESET = 8'hd9;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int EESAVE_BIT = 3;
  // Memory operations handed to the storage module
  typedef enum logic [1:0] {
    MOP_NONE, MOP_ERASE, MOP_WR_FLASH, MOP_WR_EE
  } pp_mop_t;
  // Port sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_BUSY = 3'b100
  } pp_state_t;
endpackage

/* verilog/pp_mem_if.sv */
`timescale 1ns/100ps
interface pp_mem_if;
  logic start;
  pp_pkg::pp_mop_t op;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic page_load;
  logic ee_keep;
  logic [15:0] rdata;
  logic [7:0] ee_rdata;
  logic done;
  modport ctrl (output start, op, addr, wdata, page_load, ee_keep, input rdata, ee_rdata, done);
  modport mem (input start, op, addr, wdata, page_load, ee_keep, output rdata, ee_rdata, done);
endinterface

/* verilog/pp_sync.sv */
`timescale 1ns/100ps
module pp_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Pins and synchronised copy
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] pins_out
);
  typedef struct packed {
    logic [W-1:0] stg1;
    logic [W-1:0] stg2;
  } pp_sync_state_t;

  pp_sync_state_t q, d;

  if (W < 1) begin : g_chk
    $error("pp_sync needs a width of at least one");
  end

  // First stage feeds only the second
  always_comb begin
    d.stg1 = pins_in;
    d.stg2 = q.stg1;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins_out = q.stg2;
endmodule

/* verilog/pp_nvm.sv */
`timescale 1ns/100ps
module pp_nvm (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Control side
  pp_mem_if.mem bus
);
  typedef struct packed {
    logic busy;
    pp_pkg::pp_mop_t op;
    logic [11:0] idx;
    logic done;
  } pp_nvm_state_t;

  pp_nvm_state_t q, d;
  logic [15:0] flash_mem [0:pp_pkg::FLASH_WORDS-1];
  logic [7:0] ee_mem [0:pp_pkg::EE_BYTES-1];
  logic [15:0] flash_buf [0:pp_pkg::FLASH_PAGE_WORDS-1];
  logic [7:0] ee_buf [0:pp_pkg::EE_PAGE_BYTES-1];
  logic [15:0] rdata_q;
  logic [7:0] ee_rdata_q;
  logic last;

  // Walk end for each operation
  always_comb begin
    case (q.op)
      pp_pkg::MOP_ERASE: last = (q.idx == 12'(pp_pkg::FLASH_WORDS - 1));
      pp_pkg::MOP_WR_FLASH: last = (q.idx == 12'(pp_pkg::FLASH_PAGE_WORDS - 1));
      default: last = (q.idx == 12'(pp_pkg::EE_PAGE_BYTES - 1));
    endcase
  end

  // Sequencer walks one location per cycle
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!q.busy && bus.start && bus.op != pp_pkg::MOP_NONE) begin
      d.busy = 1'b1;
      d.op = bus.op;
      d.idx = '0;
    end else if (q.busy) begin
      if (last) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.idx = q.idx + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Arrays, page buffers and read ports
  always_ff @(posedge clk_in) begin
    if (q.busy) begin
      case (q.op)
        pp_pkg::MOP_ERASE: begin
          flash_mem[q.idx] <= pp_pkg::ERASED_WORD;
          if (q.idx < 12'(pp_pkg::EE_BYTES) && !bus.ee_keep) begin
            ee_mem[q.idx[8:0]] <= pp_pkg::ERASED_BYTE;
          end
        end
        pp_pkg::MOP_WR_FLASH: flash_mem[{bus.addr[11:5], q.idx[4:0]}] <= flash_buf[q.idx[4:0]];
        pp_pkg::MOP_WR_EE: ee_mem[{bus.addr[8:2], q.idx[1:0]}] <= ee_buf[q.idx[1:0]];
        default: ;
      endcase
    end
    if (bus.page_load) begin
      if (bus.op == pp_pkg::MOP_WR_EE) begin
        ee_buf[bus.addr[1:0]] <= bus.wdata[7:0];
      end else begin
        flash_buf[bus.addr[4:0]] <= bus.wdata;
      end
    end
    rdata_q <= flash_mem[bus.addr];
    ee_rdata_q <= ee_mem[bus.addr[8:0]];
  end

  assign bus.rdata = rdata_q;
  assign bus.ee_rdata = ee_rdata_q;
  assign bus.done = q.done;
endmodule

/* testbench/pp_prog_model.sv */
`timescale 1ns/100ps
module pp_prog_model (
  // Clock
  input wire logic clk_in,
  // Device side of the data bus
  input wire logic [7:0] data_out_in,
  input wire logic data_oe_n_in,
  // Programmer pins
  output logic xtal_out,
  output logic act0_out,
  output logic act1_out,
  output logic bs1_out,
  output logic bs2_out,
  output logic pl_out,
  output logic wr_n_out,
  output logic oe_n_out,
  // Resolved bus level
  output logic [7:0] bus_out
);
  logic [7:0] drv_q;
  logic [7:0] last_q;

  initial begin
    {xtal_out, act0_out, act1_out, bs1_out, bs2_out, pl_out} = 6'h00;
    wr_n_out = 1'b1;
    oe_n_out = 1'b1;
    drv_q = 8'h00;
  end

  always_comb begin
    bus_out = !data_oe_n_in ? data_out_in : (oe_n_out ? drv_q : ~last_q);
  end
  always_ff @(posedge clk_in) last_q <= bus_out;

  ////////////////////////////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] b);
    @(posedge clk_in);
    {act1_out, act0_out} <= act;
    bs1_out <= sel;
    drv_q <= b;
    hold(5);
    xtal_out <= 1'b1;
    hold(5);
    xtal_out <= 1'b0;
    hold(4);
  endtask

  task automatic pload();
    pl_out <= 1'b1;
    hold(5);
    pl_out <= 1'b0;
    hold(5);
  endtask

  // Second select is a don't-care during writes, so it carries noise
  task automatic write(input logic sel, input logic sel2);
    bs1_out <= sel;
    bs2_out <= sel2;
    hold(5);
    wr_n_out <= 1'b0;
    hold(6);
    wr_n_out <= 1'b1;
    hold(2);
  endtask

  task automatic read(input logic s1, input logic s2, output logic [7:0] v, output logic o);
    bs1_out <= s1;
    bs2_out <= s2;
    oe_n_out <= 1'b0;
    hold(7);
    v = data_out_in;
    o = data_oe_n_in;
    oe_n_out <= 1'b1;
    hold(5);
  endtask
endmodule

/* testbench/parallel_programming_port_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module parallel_programming_port_tb;
  localparam logic [7:0] SIG0 = 8'h5a; // Arbitrary identification value
  localparam logic [7:0] SIG1 = 8'h3c; // Arbitrary identification value
  localparam logic [7:0] SIG2 = 8'h01; // Arbitrary identification value
  logic clk_in, reset_in, trim_ld, xtal, a0, a1, s1, s2, pl, wr_n, oe_n, oe_dev_n, rdy, o;
  logic [7:0] trim_d, trim_q, bus, dout, v;
  logic [15:0] d;
  logic [31:0] r;
  logic [7:0] texp;
  logic [31:0] seed = 32'h35;
  int n_errors = 0;
  int n_tests = 0;
  int base;
  logic [15:0] fmodel [int];
  logic [7:0] emodel [int];
  logic [7:0] sig [4] = '{SIG0, SIG1, SIG2, 8'hff};
  logic [7:0] cal [4] = '{pp_pkg::CAL_1MHZ, pp_pkg::CAL_2MHZ, pp_pkg::CAL_4MHZ, pp_pkg::CAL_8MHZ};
  logic [7:0] fz [4] = '{pp_pkg::FUSE_LO_RESET, pp_pkg::LOCK_RESET, 8'hff, pp_pkg::FUSE_HI_RESET};

  // Design and programmer
  pp_port #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) i_pp_port (.clk_in(clk_in),
    .reset_in(reset_in), .crystal_strobe_pin_in(xtal), .action_select_0_in(a0), .action_select_1_in(a1),
    .byte_select_lo_hi_in(s1), .byte_select_second_in(s2), .page_load_in(pl), .write_n_in(wr_n),
    .output_enable_n_in(oe_n), .data_in(bus), .data_out(dout), .data_oe_n_out(oe_dev_n),
    .ready_busy_out(rdy), .osc_trim_load_in(trim_ld), .osc_trim_data_in(trim_d), .osc_trim_reg_out(trim_q));
  pp_prog_model i_prog (.clk_in(clk_in), .data_out_in(dout), .data_oe_n_in(oe_dev_n), .xtal_out(xtal),
    .act0_out(a0), .act1_out(a1), .bs1_out(s1), .bs2_out(s2), .pl_out(pl), .wr_n_out(wr_n),
    .oe_n_out(oe_n), .bus_out(bus));

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bounded wait for the ready pin
  task automatic wait_ready();
    for (int i = 0; i < 6000 && rdy !== 1'b1; i++) @(posedge clk_in);
    `CHK(rdy, 1'b1)
  endtask

  // Clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #(60000 * 8);
    n_errors++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    reset_in = 1'b1;
    trim_ld = 1'b0;
    trim_d = 8'h00;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    i_prog.hold(2);
    `CHK(oe_dev_n, 1'b1)
    i_prog.hold(2);
    `CHK(trim_q, pp_pkg::CAL_1MHZ)
    `CHK(oe_dev_n, 1'b1)
    `CHK(rdy, 1'b1)
    // Random trim loads, the last one taken must stand
    for (int i = 0; i < 8; i++) begin
      r = xs();
      trim_d <= r[7:0];
      trim_ld <= r[8] || i == 0;
      if (r[8] || i == 0) begin
        texp = r[7:0];
      end
      i_prog.hold(1);
    end
    trim_ld <= 1'b0;
    i_prog.hold(2);
    `CHK(trim_q, texp)
    $display("test reset and trim done");
    // Identification and calibration rows
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_SIG);
    for (int a = 0; a < 4; a++) begin
      i_prog.load(pp_pkg::ACT_ADDR, 1'b0, 8'(a));
      i_prog.read(1'b0, 1'b0, v, o);
      `CHK(v, sig[a])
      `CHK(o, 1'b0)
      i_prog.read(1'b1, 1'b0, v, o);
      `CHK(v, cal[a])
      `CHK(oe_dev_n, 1'b1)
    end
    // Fuse and lock row, every select pair
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_FUSE);
    for (int k = 0; k < 4; k++) begin
      i_prog.read(k[0], k[1], v, o);
      `CHK(v, fz[k])
    end
    $display("test read rows done");
    // Erase with a strobe during busy that must be ignored
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_ERASE);
    i_prog.write(1'(xs()), 1'(xs()));
    `CHK(rdy, 1'b0)
    i_prog.load(pp_pkg::ACT_ADDR, 1'b0, 8'h00);
    wait_ready();
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_SIG);
    i_prog.read(1'b1, 1'b0, v, o);
    `CHK(v, pp_pkg::CAL_8MHZ)
    $display("test erase done");
    // Flash page write, first words and last word of a page
    base = int'(xs() % 128) * pp_pkg::FLASH_PAGE_WORDS;
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_WR_FLASH);
    for (int k = 0; k < 4; k++) begin
      d = 16'(xs());
      fmodel[base + (k == 3 ? 31 : k)] = d;
      i_prog.load(pp_pkg::ACT_ADDR, 1'b0, 8'(base + (k == 3 ? 31 : k)));
      i_prog.load(pp_pkg::ACT_DATA, 1'b0, d[7:0]);
      i_prog.load(pp_pkg::ACT_DATA, 1'b1, d[15:8]);
      i_prog.pload();
    end
    i_prog.load(pp_pkg::ACT_ADDR, 1'b1, 8'(base >> 8));
    i_prog.write(1'(xs()), 1'(xs()));
    `CHK(rdy, 1'b0)
    wait_ready();
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_FLASH);
    foreach (fmodel[a]) begin
      i_prog.load(pp_pkg::ACT_ADDR, 1'b0, 8'(a));
      i_prog.read(1'b0, 1'b0, v, o);
      `CHK(v, fmodel[a][7:0])
      i_prog.read(1'b1, 1'b0, v, o);
      `CHK(v, fmodel[a][15:8])
    end
    $display("test flash done");
    // EEPROM page write and read back
    base = int'(xs() % 128) * pp_pkg::EE_PAGE_BYTES;
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_WR_EE);
    for (int k = 0; k < 4; k++) begin
      v = 8'(xs());
      emodel[base + k] = v;
      i_prog.load(pp_pkg::ACT_ADDR, 1'b0, 8'(base + k));
      i_prog.load(pp_pkg::ACT_DATA, 1'b0, v);
      i_prog.pload();
    end
    i_prog.load(pp_pkg::ACT_ADDR, 1'b1, 8'(base >> 8));
    i_prog.write(1'(xs()), 1'(xs()));
    wait_ready();
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_EE);
    foreach (emodel[a]) begin
      i_prog.load(pp_pkg::ACT_ADDR, 1'b0, 8'(a));
      i_prog.read(1'b0, 1'b0, v, o);
      `CHK(v, emodel[a])
    end
    $display("test eeprom done");
    // Fuse high write, read back on the high select pair
    d = 16'(xs());
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_WR_FUSE);
    i_prog.load(pp_pkg::ACT_DATA, 1'b0, d[7:0]);
    i_prog.write(1'b1, 1'(xs()));
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_FUSE);
    i_prog.read(1'b1, 1'b1, v, o);
    `CHK(v, d[7:0])
    $display("test fuse done");
    // Lock, then fuse write refused, memory blank, identification readable
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_WR_LOCK);
    i_prog.load(pp_pkg::ACT_DATA, 1'b0, 8'hfc);
    i_prog.write(1'(xs()), 1'(xs()));
    i_prog.hold(10);
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_FUSE);
    i_prog.read(1'b1, 1'b0, v, o);
    `CHK(v, 8'hfc)
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_WR_FUSE);
    i_prog.load(pp_pkg::ACT_DATA, 1'b0, ~d[7:0]);
    i_prog.write(1'b1, 1'(xs()));
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_FUSE);
    i_prog.read(1'b1, 1'b1, v, o);
    `CHK(v, d[7:0])
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_EE);
    i_prog.load(pp_pkg::ACT_ADDR, 1'b0, 8'(base));
    i_prog.read(1'b0, 1'b0, v, o);
    `CHK(v, pp_pkg::ERASED_BYTE)
    i_prog.load(pp_pkg::ACT_CMD, 1'b0, pp_pkg::CMD_RD_SIG);
    i_prog.load(pp_pkg::ACT_ADDR, 1'b0, 8'h00);
    i_prog.read(1'b0, 1'b0, v, o);
    `CHK(v, SIG0)
    // Idle action code latches nothing
    i_prog.load(pp_pkg::ACT_IDLE, 1'b0, 8'(xs()));
    i_prog.read(1'b0, 1'b0, v, o);
    `CHK(v, SIG0)
    $display("test lock done");
    stop_test();
  end
endmodule
